// ### shared/swub_map.svh
// Purpose: offsets, field positions and reset values of the watermark/underrun/baud block
// Assumes: word-indexed register port, 32-bit data, low bits used
// Notes: definitions only
`ifndef SWUB_MAP_SVH
`define SWUB_MAP_SVH

`define SWUB_A_DATA 4'h0
`define SWUB_A_CTRL 4'h1
`define SWUB_A_DIV 4'h2
`define SWUB_A_CNT 4'h3
`define SWUB_A_WMH 4'h4
`define SWUB_A_URL 4'h5
`define SWUB_A_URH 4'h6
`define SWUB_A_IST 4'h7
`define SWUB_A_IMSK 4'h8

`define SWUB_CTRL_EN 0
`define SWUB_CTRL_SEL 1
`define SWUB_CTRL_WL_LO 8

`define SWUB_WMH_RXEN 15
`define SWUB_WMH_RX_LO 8
`define SWUB_WMH_TXEN 7
`define SWUB_WMH_TX_LO 0

`define SWUB_IST_RXWM 0
`define SWUB_IST_TXWM 1
`define SWUB_IST_UR 2

`define SWUB_DEPTH 6'h10
`define SWUB_THR_MASK 6'h2F

`define SWUB_RST_16 16'h0000
`define SWUB_RST_13 13'h0000
`define SWUB_RST_6 6'h00
`define SWUB_RST_32 32'h00000000
`define SWUB_RST_WL 5'h00
`define SWUB_RST_IRQ 3'h0

`endif

// ### shared/swub_pkg.sv
// Purpose: types shared by the watermark/underrun/baud block
// Assumes: constants live in swub_map.svh
// Notes: none
`default_nettype none

package swub_pkg;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } swub_bus_s;

   typedef struct packed {
      logic tx_pop;
      logic rx_push;
      logic [31:0] rx_data;
   } swub_eng_s;

   typedef struct packed {
      logic port_en;
      logic fill_sel;
      logic [4:0] wl;
      logic [12:0] div;
      logic [12:0] div_cnt;
      logic sck;
      logic rx_en;
      logic tx_en;
      logic [5:0] rx_thr;
      logic [5:0] tx_thr;
      logic [15:0] fill_lo;
      logic [15:0] fill_hi;
      logic [5:0] rx_cnt;
      logic [5:0] tx_cnt;
      logic [2:0] irq_st;
      logic [2:0] irq_msk;
      logic rx_wm;
      logic tx_wm;
      logic [31:0] rdata;
      logic [31:0] ur_word;
      logic ur_pulse;
      logic tx_push;
      logic [31:0] tx_data;
   } swub_state_s;

endpackage

`default_nettype wire

// ### testbench/swub_eng_model.sv
// Purpose: shift engine stand-in that pops transmit words and pushes received ones
// Assumes: same clock as the block, requests launched just after a rising edge
// Notes: rx_data inverts between pushes so a stale word never passes as fresh
`timescale 1ns/100ps
`default_nettype none

module swub_eng_model
   import swub_pkg::*;
(
   input wire logic clk,
   output var swub_eng_s eng
);
   initial begin
      eng = '0;
   end

   task automatic push(input logic [31:0] d);
      @(posedge clk);
      eng.rx_push <= 1'b1;
      eng.rx_data <= d;
      @(posedge clk);
      eng.rx_push <= 1'b0;
      eng.rx_data <= ~d;
   endtask

   task automatic pop();
      @(posedge clk);
      eng.tx_pop <= 1'b1;
      @(posedge clk);
      eng.tx_pop <= 1'b0;
   endtask
endmodule

`default_nettype wire

// ### testbench/swub_top_bench.sv
// Purpose: register, watermark, underrun and serial clock checks of swub_top
// Assumes: engine model drives pops and pushes, bench drives the register port
// Notes: fill registers hold distinct bytes so each word-length slice is visible
`timescale 1ns/100ps
`default_nettype none
`include "swub_map.svh"

module swub_top_bench
   import swub_pkg::*;
();
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   swub_bus_s bus = '0;
   swub_eng_s eng;
   logic [31:0] rdata, tx_data, fill_word, d;
   logic tx_push, underrun, rx_wm, tx_wm, sck, irq;
   int bad_count = 0;
   int tests_run = 0;
   int n;
   logic [4:0] wl_tab [9] = '{5'h08, 5'h08, 5'h02, 5'h09, 5'h10, 5'h11, 5'h18, 5'h19, 5'h00};

   always #10 clk = ~clk;

   swub_top swub_top_i (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .eng(eng),
      .tx_push(tx_push), .tx_data(tx_data), .underrun(underrun),
      .underrun_fill_word(fill_word), .rx_watermark(rx_wm), .tx_watermark(tx_wm),
      .sck(sck), .irq(irq));
   swub_eng_model swub_eng_model_i (.clk(clk), .eng(eng));

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   // Read data exist only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
      rd(a, d);
      chk(d, exp);
   endtask

   task automatic wait_cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic sck_rise(output int k);
      logic prev;
      k = 0;
      prev = sck;
      repeat (100) begin
         @(posedge clk);
         #1 k++;
         if (sck === 1'b1 && prev === 1'b0) return;
         prev = sck;
      end
      $display("Error at %0t: serial clock wait ran out", $time);
      bad_count++;
      final_report();
   endtask

   function automatic logic [31:0] fill_exp(input logic sel, input logic [4:0] wl);
      if (!sel) return 32'h0;
      if (wl == 5'h00 || wl > 5'h18) return 32'h5A3CA5C3;
      if (wl > 5'h10) return 32'h003CA5C3;
      if (wl > 5'h08) return 32'h0000A5C3;
      return 32'h000000C3;
   endfunction

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rchk(`SWUB_A_WMH, 32'h0);
      rchk(`SWUB_A_URL, 32'h0);
      rchk(`SWUB_A_URH, 32'h0);
      rchk(4'hF, 32'h0);
      wr(`SWUB_A_WMH, 32'hFFFF);
      rchk(`SWUB_A_WMH, {16'h0, 2'b10, `SWUB_THR_MASK, 2'b10, `SWUB_THR_MASK});
      wr(`SWUB_A_WMH, 32'h0);
      wr(`SWUB_A_URL, 32'hA5C3);
      wr(`SWUB_A_URH, 32'h5A3C);
      rchk(`SWUB_A_URH, 32'h5A3C);
      // First entry has the select clear, so the fill registers must be ignored
      for (int i = 0; i < 9; i++) begin
         wr(`SWUB_A_CTRL, {19'h0, wl_tab[i], 6'h0, i != 0, 1'b0});
         swub_eng_model_i.pop();
         #1 chk({31'h0, underrun}, 32'h1);
         chk(fill_word, fill_exp(i != 0, wl_tab[i]));
      end
      rchk(`SWUB_A_IST, 32'h4);
      chk({31'h0, irq}, 32'h0);
      wr(`SWUB_A_IMSK, 32'h4);
      wait_cyc(1);
      chk({31'h0, irq}, 32'h1);
      wr(`SWUB_A_IST, 32'h4);
      wait_cyc(1);
      chk({31'h0, irq}, 32'h0);
      wr(`SWUB_A_IMSK, 32'h1);
      // Threshold 32 lies above the depth of 16; the last push is refused
      wr(`SWUB_A_WMH, 32'hA000);
      for (int i = 0; i < 17; i++) swub_eng_model_i.push(32'(i));
      wait_cyc(3);
      chk({31'h0, rx_wm}, 32'h0);
      rchk(`SWUB_A_CNT, 32'h1000);
      wr(`SWUB_A_WMH, 32'h8300);
      wait_cyc(3);
      chk({31'h0, rx_wm}, 32'h1);
      rchk(`SWUB_A_DATA, ~32'h10);
      for (int i = 0; i < 12; i++) rd(`SWUB_A_DATA, d);
      wait_cyc(3);
      chk({31'h0, rx_wm}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rd(`SWUB_A_DATA, d);
      wait_cyc(3);
      chk({31'h0, rx_wm}, 32'h0);
      wr(`SWUB_A_IST, 32'h1);
      wait_cyc(1);
      chk({31'h0, irq}, 32'h0);
      wr(`SWUB_A_WMH, 32'h0200);
      wait_cyc(3);
      chk({31'h0, rx_wm}, 32'h0);
      wr(`SWUB_A_WMH, 32'h8200);
      wait_cyc(3);
      chk({31'h0, rx_wm}, 32'h1);
      wr(`SWUB_A_WMH, 32'h0082);
      for (int i = 0; i < 3; i++) begin
         wr(`SWUB_A_DATA, 32'hC0DE0000 | 32'(i));
         #1 chk({31'h0, tx_push}, 32'h1);
         chk(tx_data, 32'hC0DE0000 | 32'(i));
         wait_cyc(3);
         chk({31'h0, tx_wm}, {31'h0, i == 1});
      end
      rchk(`SWUB_A_CNT, 32'h0203);
      // Divisor is written only while the port is off
      wr(`SWUB_A_DIV, 32'h2);
      wr(`SWUB_A_CTRL, 32'h1);
      sck_rise(n);
      sck_rise(n);
      chk(32'(n), 32'h6);
      wr(`SWUB_A_CTRL, 32'h0);
      wait_cyc(2);
      chk({31'h0, sck}, 32'h0);
      final_report();
   end

   initial begin
      #1000000;
      $display("Error at %0t: run ran out of time", $time);
      bad_count++;
      final_report();
   end
endmodule

`default_nettype wire

// ### verilog/swub_top.sv
// Purpose: watermark interrupts, underrun fill word and serial clock divider
// Assumes: shift engine and FIFO storage sit outside, on the same clock
// Notes: registers on a plain strobe port, read data one cycle later
// How it works
// - With rx enable set, flag rx watermark while threshold is at most rx count.
// - With tx enable set, flag tx watermark while threshold equals tx count.
// - Mask-high register holds rx threshold 13:8, tx threshold 5:0, with enables.
// - Thresholds above the buffer depth never match.
// - Threshold bits 2, 3, 4 exist only for depths 8, 16, 32.
// - Bits 14 and 6 of mask-high read as zero.
// - Underrun sends the fill word when select is set, else fill registers ignored.
// - Low fill register: 16 bits for 9-16 bit words, 8 bits for 2-8.
// - High fill register: 16 bits for 25-32 bit words, 8 bits for 17-24.
// - Serial clock equals bus clock over two times the sum of divisor and one.
// - Six-bit rx and tx element counts track occupancy and feed comparisons.
`timescale 1ns/100ps
`default_nettype none
`include "swub_map.svh"

module swub_top
   import swub_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire swub_bus_s bus,
   output logic [31:0] rdata,
   input wire swub_eng_s eng,
   output logic tx_push,
   output logic [31:0] tx_data,
   output logic underrun,
   output logic [31:0] underrun_fill_word,
   output logic rx_watermark,
   output logic tx_watermark,
   output logic sck,
   output logic irq
);

   swub_state_s st;
   swub_state_s next_st;

   // Threshold usable only when not beyond the buffer depth
   function automatic logic thr_ok(input logic [5:0] thr);
      thr_ok = (thr <= `SWUB_DEPTH);
   endfunction

   // Picks the fill bits the current word length uses
   function automatic logic [31:0] fill_word(
      input logic [15:0] lo,
      input logic [15:0] hi,
      input logic [4:0] wl
   );
      logic [5:0] len;
      len = (wl == 5'h00) ? 6'h20 : {1'b0, wl};
      if (len <= 6'h08) begin
         fill_word = {24'h000000, lo[7:0]};
      end else if (len <= 6'h10) begin
         fill_word = {16'h0000, lo};
      end else if (len <= 6'h18) begin
         fill_word = {8'h00, hi[7:0], lo};
      end else begin
         fill_word = {hi, lo};
      end
   endfunction

   logic wr_data;
   logic rd_data;
   logic tx_full;
   logic rx_full;
   logic ur_now;
   logic rx_hit;
   logic tx_hit;
   logic [2:0] ist_set;
   logic [2:0] ist_clr;
   logic [31:0] rd_mux;

   assign wr_data = bus.wr && (bus.addr == `SWUB_A_DATA);
   assign rd_data = bus.rd && (bus.addr == `SWUB_A_DATA);
   assign tx_full = (st.tx_cnt >= `SWUB_DEPTH);
   assign rx_full = (st.rx_cnt >= `SWUB_DEPTH);
   // Pull from an empty transmit queue is the underrun
   assign ur_now = eng.tx_pop && (st.tx_cnt == 6'h00);

   // Levels, not edges: software sees them as long as they hold
   assign rx_hit = st.rx_en && thr_ok(st.rx_thr) && (st.rx_thr <= st.rx_cnt);
   assign tx_hit = st.tx_en && thr_ok(st.tx_thr) && (st.tx_thr == st.tx_cnt);

   assign ist_set = {ur_now, tx_hit, rx_hit};
   assign ist_clr = (bus.wr && (bus.addr == `SWUB_A_IST)) ? bus.wdata[2:0] : 3'h0;

   always_comb begin
      rd_mux = 32'h00000000;
      case (bus.addr)
         `SWUB_A_DATA: begin
            rd_mux = eng.rx_data;
         end
         `SWUB_A_CTRL: begin
            rd_mux[`SWUB_CTRL_EN] = st.port_en;
            rd_mux[`SWUB_CTRL_SEL] = st.fill_sel;
            rd_mux[`SWUB_CTRL_WL_LO +: 5] = st.wl;
         end
         `SWUB_A_DIV: begin
            rd_mux[12:0] = st.div;
         end
         `SWUB_A_CNT: begin
            rd_mux[13:8] = st.rx_cnt;
            rd_mux[5:0] = st.tx_cnt;
         end
         `SWUB_A_WMH: begin
            // Bits 14 and 6 stay zero
            rd_mux[`SWUB_WMH_RXEN] = st.rx_en;
            rd_mux[`SWUB_WMH_RX_LO +: 6] = st.rx_thr;
            rd_mux[`SWUB_WMH_TXEN] = st.tx_en;
            rd_mux[`SWUB_WMH_TX_LO +: 6] = st.tx_thr;
         end
         `SWUB_A_URL: begin
            rd_mux[15:0] = st.fill_lo;
         end
         `SWUB_A_URH: begin
            rd_mux[15:0] = st.fill_hi;
         end
         `SWUB_A_IST: begin
            rd_mux[2:0] = st.irq_st;
         end
         `SWUB_A_IMSK: begin
            rd_mux[2:0] = st.irq_msk;
         end
         default: begin
            rd_mux = 32'h00000000;
         end
      endcase
   end

   always_comb begin
      next_st = st;
      next_st.tx_push = 1'b0;
      next_st.ur_pulse = 1'b0;
      next_st.rx_wm = rx_hit;
      next_st.tx_wm = tx_hit;
      next_st.rdata = bus.rd ? rd_mux : 32'h00000000;

      if (bus.wr) begin
         case (bus.addr)
            `SWUB_A_CTRL: begin
               next_st.port_en = bus.wdata[`SWUB_CTRL_EN];
               next_st.fill_sel = bus.wdata[`SWUB_CTRL_SEL];
               next_st.wl = bus.wdata[`SWUB_CTRL_WL_LO +: 5];
            end
            `SWUB_A_DIV: begin
               // Taken any time; changing it while enabled is software's fault
               next_st.div = bus.wdata[12:0];
            end
            `SWUB_A_WMH: begin
               next_st.rx_en = bus.wdata[`SWUB_WMH_RXEN];
               next_st.tx_en = bus.wdata[`SWUB_WMH_TXEN];
               next_st.rx_thr = bus.wdata[`SWUB_WMH_RX_LO +: 6] & `SWUB_THR_MASK;
               next_st.tx_thr = bus.wdata[`SWUB_WMH_TX_LO +: 6] & `SWUB_THR_MASK;
            end
            `SWUB_A_URL: begin
               next_st.fill_lo = bus.wdata[15:0];
            end
            `SWUB_A_URH: begin
               next_st.fill_hi = bus.wdata[15:0];
            end
            `SWUB_A_IMSK: begin
               next_st.irq_msk = bus.wdata[2:0];
            end
            default: begin
            end
         endcase
      end

      // Write to the window queues transmit data; a full queue drops it
      if (wr_data && !tx_full) begin
         next_st.tx_push = 1'b1;
         next_st.tx_data = bus.wdata;
      end

      // Element counts; push and pop in one cycle cancel out
      case ({wr_data && !tx_full, eng.tx_pop && !ur_now})
         2'b10: next_st.tx_cnt = st.tx_cnt + 6'h01;
         2'b01: next_st.tx_cnt = st.tx_cnt - 6'h01;
         default: next_st.tx_cnt = st.tx_cnt;
      endcase
      case ({eng.rx_push && !rx_full, rd_data && (st.rx_cnt != 6'h00)})
         2'b10: next_st.rx_cnt = st.rx_cnt + 6'h01;
         2'b01: next_st.rx_cnt = st.rx_cnt - 6'h01;
         default: next_st.rx_cnt = st.rx_cnt;
      endcase

      // Fill word only when selected, zero word otherwise
      if (ur_now) begin
         next_st.ur_pulse = 1'b1;
         if (st.fill_sel) begin
            next_st.ur_word = fill_word(st.fill_lo, st.fill_hi, st.wl);
         end else begin
            next_st.ur_word = 32'h00000000;
         end
      end

      // Half period is div+1 bus clocks
      if (!st.port_en) begin
         next_st.div_cnt = 13'h0000;
         next_st.sck = 1'b0;
      end else if (st.div_cnt >= st.div) begin
         next_st.div_cnt = 13'h0000;
         next_st.sck = !st.sck;
      end else begin
         next_st.div_cnt = st.div_cnt + 13'h0001;
      end

      // Set wins over a write-one clear in the same cycle
      next_st.irq_st = (st.irq_st & ~ist_clr) | ist_set;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st.port_en <= 1'b0;
         st.fill_sel <= 1'b0;
         st.wl <= `SWUB_RST_WL;
         st.div <= `SWUB_RST_13;
         st.div_cnt <= `SWUB_RST_13;
         st.sck <= 1'b0;
         st.rx_en <= 1'b0;
         st.tx_en <= 1'b0;
         st.rx_thr <= `SWUB_RST_6;
         st.tx_thr <= `SWUB_RST_6;
         st.fill_lo <= `SWUB_RST_16;
         st.fill_hi <= `SWUB_RST_16;
         st.rx_cnt <= `SWUB_RST_6;
         st.tx_cnt <= `SWUB_RST_6;
         st.irq_st <= `SWUB_RST_IRQ;
         st.irq_msk <= `SWUB_RST_IRQ;
         st.rx_wm <= 1'b0;
         st.tx_wm <= 1'b0;
         st.rdata <= `SWUB_RST_32;
         st.ur_word <= `SWUB_RST_32;
         st.ur_pulse <= 1'b0;
         st.tx_push <= 1'b0;
         st.tx_data <= `SWUB_RST_32;
      end else begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign tx_push = st.tx_push;
   assign tx_data = st.tx_data;
   assign underrun = st.ur_pulse;
   assign underrun_fill_word = st.ur_word;
   assign rx_watermark = st.rx_wm;
   assign tx_watermark = st.tx_wm;
   assign sck = st.sck;
   assign irq = |(st.irq_st & st.irq_msk);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_rx_wm_level: assert property (
      (st.rx_en && st.rx_thr <= st.rx_cnt && st.rx_thr <= `SWUB_DEPTH) |=> rx_watermark)
      else $error("rx watermark missing");

   chk_rx_wm_off: assert property (
      !st.rx_en |=> !rx_watermark)
      else $error("rx watermark while disabled");

   chk_tx_wm_equal: assert property (
      tx_watermark |-> $past(st.tx_en) && ($past(st.tx_thr) == $past(st.tx_cnt)))
      else $error("tx watermark without equal count");

   chk_thr_depth: assert property (
      (st.rx_thr > `SWUB_DEPTH) |=> !rx_watermark)
      else $error("threshold beyond depth matched");

   chk_thr_bits: assert property (
      ((st.rx_thr & ~`SWUB_THR_MASK) == 6'h00) && ((st.tx_thr & ~`SWUB_THR_MASK) == 6'h00))
      else $error("unimplemented threshold bit set");

   chk_wmh_read: assert property (
      (bus.rd && bus.addr == `SWUB_A_WMH) |=> !rdata[14] && !rdata[6]
         && (rdata[13:8] == $past(st.rx_thr)))
      else $error("mask-high readback wrong");

   chk_fill_ignored: assert property (
      (ur_now && !st.fill_sel) |=> underrun && (underrun_fill_word == 32'h00000000))
      else $error("fill word used while not selected");

   chk_fill_short: assert property (
      (ur_now && st.fill_sel && st.wl >= 5'h02 && st.wl <= 5'h08)
         |=> underrun_fill_word == {24'h000000, $past(st.fill_lo[7:0])})
      else $error("short fill word wrong");

   chk_fill_high: assert property (
      (ur_now && st.fill_sel && st.wl >= 5'h11 && st.wl <= 5'h18)
         |=> underrun_fill_word[31:24] == 8'h00)
      else $error("17-24 bit fill word wrong");

   chk_sck_toggle: assert property (
      (st.port_en && st.div_cnt >= st.div) |=> sck != $past(sck) && st.div_cnt == 13'h0000)
      else $error("serial clock missed its edge");

   chk_cnt_bound: assert property (
      st.tx_cnt <= `SWUB_DEPTH && st.rx_cnt <= `SWUB_DEPTH)
      else $error("element count beyond depth");

   chk_tx_wm_off: assert property (
      !st.tx_en |=> !tx_watermark)
      else $error("tx watermark while disabled");

   chk_tx_depth: assert property (
      (st.tx_thr > `SWUB_DEPTH) |=> !tx_watermark)
      else $error("tx threshold beyond depth matched");

   chk_fill_mid: assert property (
      (ur_now && st.fill_sel && st.wl >= 5'h09 && st.wl <= 5'h10)
         |=> underrun_fill_word == {16'h0000, $past(st.fill_lo)})
      else $error("16-bit fill word wrong");

   chk_fill_full: assert property (
      (ur_now && st.fill_sel && (st.wl == 5'h00 || st.wl >= 5'h19))
         |=> underrun_fill_word == {$past(st.fill_hi), $past(st.fill_lo)})
      else $error("32-bit fill word wrong");

   chk_sck_idle: assert property (
      !st.port_en |=> !sck && st.div_cnt == 13'h0000)
      else $error("serial clock running while port off");

   chk_rx_status: assert property (
      rx_hit |=> st.irq_st[`SWUB_IST_RXWM])
      else $error("rx watermark status not set");

   chk_tx_status: assert property (
      tx_hit |=> st.irq_st[`SWUB_IST_TXWM])
      else $error("tx watermark status not set");

   chk_ur_status: assert property (
      ur_now |=> underrun && st.irq_st[`SWUB_IST_UR])
      else $error("underrun status not set");

   chk_wmh_tx_read: assert property (
      (bus.rd && bus.addr == `SWUB_A_WMH) |=> (rdata[5:0] == $past(st.tx_thr))
         && rdata[15] == $past(st.rx_en) && rdata[7] == $past(st.tx_en))
      else $error("mask-high enable or tx threshold readback wrong");

   cov_underrun_fill: cover property (ur_now && st.fill_sel);
   cov_rx_wm: cover property ($rose(rx_watermark));
   cov_tx_wm: cover property ($rose(tx_watermark));
   cov_irq: cover property ($rose(irq));

endmodule

`default_nettype wire
